// *** ihd_cfg.svh ***
// Offsets, reset values, field positions and timing counts of the inrush detector
`ifndef IHD_CFG_SVH
`define IHD_CFG_SVH
`define IHD_CUR_W 16
`define IHD_PCT_W 7
`define IHD_DLY_W 16
`define IHD_ADDR_W 8
`define IHD_OFS_CTRL 8'h00
`define IHD_OFS_START 8'h04
`define IHD_OFS_OPDLY 8'h08
`define IHD_OFS_RSTDLY 8'h0C
`define IHD_OFS_NOMINAL 8'h10
`define IHD_OFS_STATUS 8'h14
`define IHD_CTRL_OP_BIT 0
`define IHD_RST_OP_ENABLE 1'h1
`define IHD_RST_START_PCT 7'h14
`define IHD_RST_OP_DLY_MS 16'h0014
`define IHD_RST_RST_DLY_MS 16'h0014
`define IHD_RST_NOMINAL 16'h03E8
`define IHD_LEVEL_PCT 7'h05
`define IHD_PCT_SCALE 7'h64
`define IHD_CLK_MHZ 250
`define IHD_TICK_MS 1
`define IHD_TICK_CYCLES (`IHD_CLK_MHZ * 1000 * `IHD_TICK_MS)
`define IHD_STAT_OUT_BIT 0
`define IHD_STAT_RATIO_LSB 1
`define IHD_STAT_LEVEL_LSB 4
`define IHD_STAT_QUAL_LSB 7
`define IHD_STAT_FSM_LSB 10
`endif

// *** ihd_checker.sv ***
// Port checks of the inrush detector
`timescale 1ns/100ps
module ihd_checker
	import ihd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire ihd_phase_t phaseA,
	input wire ihd_phase_t phaseB,
	input wire ihd_phase_t phaseC,
	input wire logic blockIn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic harmonic_block_out
);
	wire logic noHarm;
	assign noHarm = ~|{phaseA.secondHarm, phaseB.secondHarm, phaseC.secondHarm};
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence setup_s; psel && !penable; endsequence
	sequence quiet_s; noHarm [*3]; endsequence
	chk_ready_after: assert property (setup_s |=> pready)
		else $error("no pready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero when idle");
	chk_err_data: assert property (pslverr |-> prdata == 32'h0)
		else $error("prdata not zero on error");
	chk_block_clear: assert property (blockIn |=> !harmonic_block_out)
		else $error("output high while blocked");
	chk_rise_free: assert property ($rose(harmonic_block_out) |-> !$past(blockIn))
		else $error("output rose under block");
	chk_release_all: assert property (quiet_s |-> !harmonic_block_out)
		else $error("output held without harmonics");
endmodule // ihd_checker
bind ihd_inrush_detector ihd_checker u_chk(.core_clk(core_clk), .rst(rst), .phaseA(phaseA),
	.phaseB(phaseB), .phaseC(phaseC), .blockIn(blockIn), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .harmonic_block_out(harmonic_block_out));

// *** ihd_front_model.sv ***
// Front end model driving per-phase current magnitudes
`timescale 1ns/100ps
module ihd_front_model
	import ihd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [1:0] sel,
	input wire ihd_phase_t value,
	output ihd_phase_t phaseA,
	output ihd_phase_t phaseB,
	output ihd_phase_t phaseC
);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			phaseA <= '0;
			phaseB <= '0;
			phaseC <= '0;
		end else if (load && sel == 2'h3) begin
			phaseA <= '0;
			phaseB <= '0;
			phaseC <= '0;
		end else if (load) begin
			phaseA <= (sel == 2'h0) ? value : phaseA;
			phaseB <= (sel == 2'h1) ? value : phaseB;
			phaseC <= (sel == 2'h2) ? value : phaseC;
		end
	end
endmodule // ihd_front_model

// *** ihd_inrush_detector.sv ***
// Three-phase inrush detector with APB settings and definite-time timers
// Overview of operation
// - Each phase compares its second-harmonic to fundamental ratio against the start threshold.
// - Each phase reports level ok only while its fundamental exceeds five percent of nominal.
// - A definite-time operate timer counts to the operate delay, then raises the block output.
// - Once operated, the output holds until the ratio is below threshold in every phase.
// - A start drop-off while counting runs a reset timer that clears the operate timer if exceeded.
// - The block input forces the block output low, clears both timers and keeps the output from rising.
// - An operation setting of off disables the function and keeps its output low.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "ihd_cfg.svh"
module ihd_inrush_detector
	import ihd_pkg::*;
#(
	parameter int TICK_CYCLES = `IHD_TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire ihd_phase_t phaseA,
	input wire ihd_phase_t phaseB,
	input wire ihd_phase_t phaseC,
	input wire logic blockIn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`IHD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic harmonic_block_out
);
	// Settings the logic cannot serve
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least one");
	end
	if ((1 << `IHD_PCT_W) <= `IHD_PCT_SCALE) begin : g_bad_pct
		$error("percent field too narrow");
	end
	if (`IHD_STAT_QUAL_LSB + 3 > `IHD_STAT_FSM_LSB) begin : g_bad_fields
		$error("status fields overlap");
	end
	if (`IHD_STAT_FSM_LSB + 4 > 32) begin : g_bad_stat
		$error("status fields exceed the data word");
	end
	if ((1 << `IHD_ADDR_W) <= `IHD_OFS_STATUS) begin : g_bad_addr
		$error("address too narrow for the register map");
	end

	localparam ihd_core_t ST_RESET = '{
		fsm: IHD_IDLE,
		tick: '0,
		operCnt: '0,
		rstCnt: '0,
		opEnable: `IHD_RST_OP_ENABLE,
		startPct: `IHD_RST_START_PCT,
		operDelay: `IHD_RST_OP_DLY_MS,
		resetDelay: `IHD_RST_RST_DLY_MS,
		nominal: `IHD_RST_NOMINAL,
		blockOut: 1'h0,
		pready: 1'h0,
		pslverr: 1'h0,
		prdata: '0
	};

	ihd_core_t st;
	ihd_core_t next_st;
	ihd_phase_t phases [3];
	logic [2:0] ratioHit;
	logic [2:0] levelOk;
	logic [2:0] qualified;
	logic startCond;
	logic msTick;
	logic setupPhase;
	logic accessWrite;

	assign phases[0] = phaseA;
	assign phases[1] = phaseB;
	assign phases[2] = phaseC;

	// Per-phase ratio and level detectors
	for (genvar p = 0; p < 3; p++) begin : g_phase
		ihd_phase_detect u_detect (
			.core_clk(core_clk),
			.rst(rst),
			.phase(phases[p]),
			.startPct(st.startPct),
			.nominal(st.nominal),
			.ratioHit(ratioHit[p]),
			.levelOk(levelOk[p])
		);
	end

	// Offset decode used only for the error response
	function automatic logic isMapped(input logic [`IHD_ADDR_W-1:0] a);
		isMapped = (a == `IHD_OFS_CTRL) || (a == `IHD_OFS_START) ||
			(a == `IHD_OFS_OPDLY) || (a == `IHD_OFS_RSTDLY) ||
			(a == `IHD_OFS_NOMINAL) || (a == `IHD_OFS_STATUS);
	endfunction

	// Register read data
	function automatic logic [31:0] readMux(input logic [`IHD_ADDR_W-1:0] a,
		input ihd_core_t s, input logic [2:0] r, input logic [2:0] l, input logic [2:0] q);
		logic [31:0] d;
		d = '0;
		case (a)
			`IHD_OFS_CTRL: d[`IHD_CTRL_OP_BIT] = s.opEnable;
			`IHD_OFS_START: d[`IHD_PCT_W-1:0] = s.startPct;
			`IHD_OFS_OPDLY: d[`IHD_DLY_W-1:0] = s.operDelay;
			`IHD_OFS_RSTDLY: d[`IHD_DLY_W-1:0] = s.resetDelay;
			`IHD_OFS_NOMINAL: d[`IHD_CUR_W-1:0] = s.nominal;
			`IHD_OFS_STATUS: begin
				d[`IHD_STAT_OUT_BIT] = s.blockOut;
				d[`IHD_STAT_RATIO_LSB +: 3] = r;
				d[`IHD_STAT_LEVEL_LSB +: 3] = l;
				d[`IHD_STAT_QUAL_LSB +: 3] = q;
				d[`IHD_STAT_FSM_LSB +: 4] = s.fsm;
			end
			default: d = '0;
		endcase
		readMux = d;
	endfunction

	always_comb begin
		// Start condition from qualified phases
		qualified = ratioHit & levelOk;
		startCond = |qualified;
		msTick = st.tick == 32'(TICK_CYCLES - 1);
		setupPhase = psel && !penable;
		accessWrite = psel && penable && st.pready && pwrite;
		next_st = st;

		// APB slave, zero wait states
		next_st.pready = setupPhase;
		next_st.pslverr = setupPhase && !isMapped(paddr);
		if (setupPhase && !pwrite) begin
			next_st.prdata = readMux(paddr, st, ratioHit, levelOk, qualified);
		end else begin
			next_st.prdata = '0;
		end
		// Register writes in the access cycle
		if (accessWrite) begin
			case (paddr)
				`IHD_OFS_CTRL: next_st.opEnable = pwdata[`IHD_CTRL_OP_BIT];
				`IHD_OFS_START: next_st.startPct = pwdata[`IHD_PCT_W-1:0];
				`IHD_OFS_OPDLY: next_st.operDelay = pwdata[`IHD_DLY_W-1:0];
				`IHD_OFS_RSTDLY: next_st.resetDelay = pwdata[`IHD_DLY_W-1:0];
				`IHD_OFS_NOMINAL: next_st.nominal = pwdata[`IHD_CUR_W-1:0];
				default: next_st.nominal = st.nominal;
			endcase
		end

		// Millisecond tick, running in every state but idle
		if (msTick) begin
			next_st.tick = '0;
		end else begin
			next_st.tick = st.tick + 32'h00000001;
		end

		// Timer state machine
		case (st.fsm)
			IHD_IDLE: begin
				next_st.tick = '0;
				next_st.operCnt = '0;
				next_st.rstCnt = '0;
				if (startCond) begin
					next_st.fsm = IHD_RUN;
				end
			end
			IHD_RUN: begin
				if (st.operCnt >= st.operDelay) begin
					next_st.fsm = IHD_OPER;
				end else if (!startCond) begin
					next_st.fsm = IHD_DROP;
					next_st.rstCnt = '0;
				end else if (msTick) begin
					next_st.operCnt = st.operCnt + 16'h0001;
				end
			end
			IHD_DROP: begin
				if (startCond) begin
					next_st.fsm = IHD_RUN;
				end else if (st.rstCnt > st.resetDelay) begin
					next_st.fsm = IHD_IDLE;
					next_st.operCnt = '0;
				end else if (msTick) begin
					next_st.rstCnt = st.rstCnt + 16'h0001;
				end
			end
			IHD_OPER: begin
				if (!(|ratioHit)) begin
					next_st.fsm = IHD_IDLE;
				end
			end
			default: next_st.fsm = IHD_IDLE;
		endcase

		// Block input and operation setting override
		if (blockIn || !st.opEnable) begin
			next_st.fsm = IHD_IDLE;
			next_st.operCnt = '0;
			next_st.rstCnt = '0;
			next_st.tick = '0;
		end
		next_st.blockOut = (next_st.fsm == IHD_OPER);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flip-flops
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign harmonic_block_out = st.blockOut;
endmodule // ihd_inrush_detector

// *** ihd_phase_detect.sv ***
// Per-phase harmonic ratio comparator and fundamental level detector
`timescale 1ns/100ps
`include "ihd_cfg.svh"
module ihd_phase_detect
	import ihd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire ihd_phase_t phase,
	input wire logic [`IHD_PCT_W-1:0] startPct,
	input wire logic [`IHD_CUR_W-1:0] nominal,
	output logic ratioHit,
	output logic levelOk
);
	localparam int PW = `IHD_CUR_W + `IHD_PCT_W;
	ihd_phase_state_t st;
	ihd_phase_state_t next_st;
	logic [PW-1:0] secondScaled;
	logic [PW-1:0] fundScaled;
	logic [PW-1:0] fundLevel;
	logic [PW-1:0] nomLevel;

	always_comb begin
		// Ratio compared without division
		secondScaled = PW'(phase.secondHarm) * PW'(`IHD_PCT_SCALE);
		fundScaled = PW'(phase.fundamental) * PW'(startPct);
		fundLevel = PW'(phase.fundamental) * PW'(`IHD_PCT_SCALE);
		nomLevel = PW'(nominal) * PW'(`IHD_LEVEL_PCT);
		next_st.ratioHit = secondScaled > fundScaled;
		next_st.levelOk = fundLevel > nomLevel;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ratioHit = st.ratioHit;
	assign levelOk = st.levelOk;
endmodule // ihd_phase_detect

// *** ihd_pkg.sv ***
// Types shared by the inrush detector modules
`include "ihd_cfg.svh"
package ihd_pkg;
	typedef struct packed {
		logic [`IHD_CUR_W-1:0] secondHarm;
		logic [`IHD_CUR_W-1:0] fundamental;
	} ihd_phase_t;

	typedef enum logic [3:0] {
		IHD_IDLE = 4'h1,
		IHD_RUN = 4'h2,
		IHD_DROP = 4'h4,
		IHD_OPER = 4'h8
	} ihd_fsm_t;

	typedef struct packed {
		logic ratioHit;
		logic levelOk;
	} ihd_phase_state_t;

	typedef struct packed {
		ihd_fsm_t fsm;
		logic [31:0] tick;
		logic [`IHD_DLY_W-1:0] operCnt;
		logic [`IHD_DLY_W-1:0] rstCnt;
		logic opEnable;
		logic [`IHD_PCT_W-1:0] startPct;
		logic [`IHD_DLY_W-1:0] operDelay;
		logic [`IHD_DLY_W-1:0] resetDelay;
		logic [`IHD_CUR_W-1:0] nominal;
		logic blockOut;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ihd_core_t;
endpackage

// *** ihd_tb.sv ***
// Self-checking testbench for the inrush detector
`timescale 1ns/100ps
module testbench
	import ihd_pkg::*;
;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic blockIn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, load = 1'h0;
	logic pready, pslverr, harmonic_block_out, er;
	logic [1:0] sel = 2'h3;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	ihd_phase_t value = '0, phaseA, phaseB, phaseC;
	int errors = 0, n_checks = 0;
	localparam logic [31:0] RV [6] = '{32'h1, 32'h14, 32'h14, 32'h14, 32'h3E8, 32'h400};
	always #2 core_clk = ~core_clk;
	ihd_front_model fe(.core_clk(core_clk), .rst(rst), .load(load), .sel(sel), .value(value),
		.phaseA(phaseA), .phaseB(phaseB), .phaseC(phaseC));
	ihd_inrush_detector #(.TICK_CYCLES(4)) dut(.core_clk(core_clk), .rst(rst), .phaseA(phaseA),
		.phaseB(phaseB), .phaseC(phaseC), .blockIn(blockIn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .harmonic_block_out(harmonic_block_out));
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cw(input string s, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", s, x, g);
		end
	endtask
	task automatic cf(input logic x);
		cw("harmonic_block_out", {31'h0, x}, {31'h0, harmonic_block_out});
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'h1;
		do begin
			cyc(1);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		cyc(1);
	endtask
	task automatic ph(input logic [1:0] s, input logic [15:0] h, input logic [15:0] f);
		load <= 1'h1;
		sel <= s;
		value <= {h, f};
		cyc(1);
		load <= 1'h0;
		cyc(1);
	endtask
	task automatic wo(input logic x, input int c);
		int k = 0;
		while (harmonic_block_out !== x && k < c) begin
			cyc(1);
			k++;
		end
		cf(x);
	endtask
	task automatic tp(input logic [1:0] s, input logic [15:0] h, input logic [15:0] f, input logic x);
		ph(s, h, f);
		cyc(30);
		cf(x);
		ph(2'h3, 16'h0, 16'h0);
		cyc(5);
	endtask
	initial begin
		#40000;
		errors++;
		conclude;
	end
	initial begin
		cyc(8);
		rst <= 1'h0;
		cyc(1);
		for (int i = 0; i < 6; i++) begin
			rw(1'h0, 8'(i * 4), 32'h0);
			cw("register", RV[i], rd);
			cw("pslverr", 32'h0, {31'h0, er});
		end
		rw(1'h0, 8'h18, 32'h0);
		cw("pslverr", 32'h1, {31'h0, er});
		cw("prdata", 32'h0, rd);
		rw(1'h1, 8'h14, 32'hFFFF);
		rw(1'h0, 8'h14, 32'h0);
		cw("status", 32'h400, rd);
		rw(1'h1, 8'h08, 32'h2);
		tp(2'h0, 16'h00C8, 16'h03E8, 1'h0);
		tp(2'h1, 16'h00C9, 16'h03E8, 1'h1);
		tp(2'h2, 16'h001E, 16'h0032, 1'h0);
		tp(2'h2, 16'h001E, 16'h0033, 1'h1);
		ph(2'h0, 16'h012C, 16'h03E8);
		cyc(6);
		cf(1'h0);
		wo(1'h1, 20);
		ph(2'h0, 16'h012C, 16'h0);
		ph(2'h1, 16'h012C, 16'h03E8);
		ph(2'h0, 16'h0, 16'h0);
		cyc(10);
		cf(1'h1);
		ph(2'h1, 16'h0, 16'h0);
		wo(1'h0, 5);
		rw(1'h1, 8'h08, 32'h4);
		rw(1'h1, 8'h0C, 32'h1);
		ph(2'h0, 16'h012C, 16'h03E8);
		cyc(12);
		ph(2'h0, 16'h0, 16'h03E8);
		cyc(20);
		ph(2'h0, 16'h012C, 16'h03E8);
		cyc(14);
		cf(1'h0);
		wo(1'h1, 20);
		blockIn <= 1'h1;
		cyc(30);
		cf(1'h0);
		blockIn <= 1'h0;
		cyc(14);
		cf(1'h0);
		wo(1'h1, 20);
		rw(1'h1, 8'h00, 32'h0);
		cyc(30);
		cf(1'h0);
		rw(1'h1, 8'h00, 32'h1);
		wo(1'h1, 30);
		conclude;
	end
endmodule // testbench
